// ### logic/event_timer_defines.svh
// Constants of the state configurable event timer
// Overview of operation
// - One wide or two narrow counters
// - Count system clock or selected input
// - Up mode and up-down mode counting
// - Five registers, each match or capture
// - Four inputs and four outputs per instance
// - Capture counter on match or edge
// - Four PWM outputs, shared period
// - Events from match, edge, level, combination
// - Events limit, halt, start, stop, reverse
// - Events change state, toggle, interrupt, DMA
// - Match register 0 as auto limit
// - Events qualified by count direction
// - Match held until qualifying event
// - Events active only in assigned states
// - Event moves state variable on
// - State survives counter wrap and limit
// - All actions in hardware, no processor
// - Match ORed with timer matches, converter trigger
`ifndef EVENT_TIMER_DEFINES_SVH
`define EVENT_TIMER_DEFINES_SVH
`define ET_CNT_W       32
`define ET_HALF_W      16
`define ET_NUM_MR      5
`define ET_NUM_EV      6
`define ET_NUM_ST      8
`define ET_ST_W        3
`define ET_NUM_IO      4
`define ET_NUM_CNT     2
`define ET_FULL_LIM    32'hFFFFFFFF
`define ET_HALF_LIM    32'h0000FFFF
`define ET_RST_STATE   3'h0
`define ET_RST_OUT     4'h0
`endif

// ### logic/event_timer_pkg.sv
// Types of the state configurable event timer
`include "event_timer_defines.svh"
package event_timer_pkg;
    typedef enum logic [1:0] {
        COND_LOW  = 2'b00,
        COND_RISE = 2'b01,
        COND_FALL = 2'b10,
        COND_HIGH = 2'b11
    } io_cond_e;
    typedef enum logic [1:0] {
        COMB_OR    = 2'b00,
        COMB_MATCH = 2'b01,
        COMB_IO    = 2'b10,
        COMB_AND   = 2'b11
    } comb_e;
    typedef enum logic [1:0] {
        DIRQ_ANY  = 2'b00,
        DIRQ_UP   = 2'b01,
        DIRQ_DOWN = 2'b10,
        DIRQ_NONE = 2'b11
    } dir_qual_e;
    typedef logic [`ET_CNT_W-1:0] word_t;
endpackage : event_timer_pkg

// ### logic/state_event_timer.sv
// State configurable event timer: counters, match/capture, events, state variable
`timescale 1ns/10ps
`include "event_timer_defines.svh"
module state_event_timer
    import event_timer_pkg::*;
(
    input  wire logic                                  clk,
    input  wire logic                                  rst,
    input  wire logic                                  cfg_unify,
    input  wire logic [`ET_NUM_CNT-1:0]                cfg_clk_from_pin,
    input  wire logic [`ET_NUM_CNT-1:0][1:0]           cfg_clk_pin,
    input  wire logic [`ET_NUM_CNT-1:0]                cfg_bidir,
    input  wire logic [`ET_NUM_CNT-1:0]                cfg_auto_limit,
    input  wire logic [`ET_NUM_MR-1:0]                 cfg_is_capture,
    input  wire logic [`ET_NUM_MR-1:0][`ET_CNT_W-1:0]  match_value,
    input  wire logic [`ET_NUM_CNT-1:0]                sw_run,
    input  wire logic [`ET_NUM_EV-1:0][`ET_NUM_ST-1:0] ev_state_mask,
    input  wire logic [`ET_NUM_EV-1:0]                 ev_counter,
    input  wire logic [`ET_NUM_EV-1:0][2:0]            ev_match_sel,
    input  wire logic [`ET_NUM_EV-1:0][2:0]            ev_io_sel,
    input  wire logic [`ET_NUM_EV-1:0][1:0]            ev_io_cond,
    input  wire logic [`ET_NUM_EV-1:0][1:0]            ev_comb,
    input  wire logic [`ET_NUM_EV-1:0][1:0]            ev_dir_qual,
    input  wire logic [`ET_NUM_EV-1:0]                 ev_hold,
    input  wire logic [`ET_NUM_EV-1:0]                 ev_limit,
    input  wire logic [`ET_NUM_EV-1:0]                 ev_halt,
    input  wire logic [`ET_NUM_EV-1:0]                 ev_stop,
    input  wire logic [`ET_NUM_EV-1:0]                 ev_start,
    input  wire logic [`ET_NUM_EV-1:0]                 ev_reverse,
    input  wire logic [`ET_NUM_EV-1:0]                 ev_goto_en,
    input  wire logic [`ET_NUM_EV-1:0][`ET_ST_W-1:0]   ev_goto_state,
    input  wire logic [`ET_NUM_EV-1:0][`ET_NUM_IO-1:0] ev_out_toggle,
    input  wire logic [`ET_NUM_EV-1:0][`ET_NUM_MR-1:0] ev_capture,
    input  wire logic [`ET_NUM_EV-1:0]                 ev_irq_en,
    input  wire logic [`ET_NUM_EV-1:0]                 ev_dma_en,
    input  wire logic [`ET_NUM_IO-1:0]                 in_pins,
    input  wire logic [`ET_NUM_IO-1:0]                 gp_match,
    output logic      [`ET_CNT_W-1:0]                  count_value,
    output logic      [`ET_NUM_CNT-1:0]                count_down,
    output logic      [`ET_NUM_CNT-1:0]                count_running,
    output logic      [`ET_NUM_MR-1:0][`ET_CNT_W-1:0]  capture_value,
    output logic      [`ET_ST_W-1:0]                   state_value,
    output logic      [`ET_NUM_IO-1:0]                 out_pins,
    output logic      [`ET_NUM_EV-1:0]                 irq_event,
    output logic                                       dma_req,
    output logic      [`ET_NUM_IO-1:0]                 adc_trig
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    word_t                           cnt_reg [`ET_NUM_CNT];
    word_t                           cnt_next [`ET_NUM_CNT];
    logic  [`ET_NUM_CNT-1:0]         dir_reg;
    logic  [`ET_NUM_CNT-1:0]         dir_next;
    logic  [`ET_NUM_CNT-1:0]         halt_reg;
    logic  [`ET_NUM_CNT-1:0]         stop_reg;
    logic  [`ET_NUM_CNT-1:0]         tick;
    logic  [`ET_NUM_CNT-1:0]         active;
    logic  [`ET_NUM_CNT-1:0]         act_limit;
    logic  [`ET_NUM_CNT-1:0]         act_halt;
    logic  [`ET_NUM_CNT-1:0]         act_stop;
    logic  [`ET_NUM_CNT-1:0]         act_start;
    logic  [`ET_NUM_CNT-1:0]         act_rev;
    logic  [`ET_NUM_IO-1:0]          in_s1_reg;
    logic  [`ET_NUM_IO-1:0]          in_s2_reg;
    logic  [`ET_NUM_IO-1:0]          in_s3_reg;
    logic  [`ET_NUM_IO-1:0]          in_clean_reg;
    logic  [`ET_NUM_IO-1:0]          in_prev_reg;
    logic  [`ET_NUM_IO-1:0]          out_reg;
    logic  [`ET_NUM_IO-1:0]          out_prev_reg;
    logic  [`ET_NUM_IO-1:0]          out_next;
    logic  [`ET_ST_W-1:0]            state_reg;
    logic  [`ET_ST_W-1:0]            state_next;
    logic  [`ET_NUM_EV-1:0]          pend_reg;
    logic  [`ET_NUM_EV-1:0]          raw_match;
    logic  [`ET_NUM_EV-1:0]          fire;
    logic  [`ET_NUM_MR-1:0]          cap_load;
    logic  [`ET_NUM_MR-1:0]          mr_hit;
    word_t                           cap_reg [`ET_NUM_MR];
    logic  [`ET_NUM_EV-1:0]          irq_reg;
    logic                            dma_reg;
    logic  [`ET_NUM_IO-1:0]          adc_reg;

    ////////////////////////////////////////////////////////////////////////
    // Helpers
    // Compare value for counter c: upper half of a match word feeds counter 1
    function automatic word_t half_of(input word_t w, input logic c, input logic wide);
        half_of = wide ? w : (c ? {16'h0000, w[31:16]} : {16'h0000, w[15:0]});
    endfunction : half_of

    // Whether match register r (0..4) equals counter c
    function automatic logic hit_of(input word_t cv, input word_t mv, input logic c,
                                    input logic wide);
        hit_of = (cv == half_of(mv, c, wide));
    endfunction : hit_of

    ////////////////////////////////////////////////////////////////////////
    // Input synchroniser, three stages; value accepted once s2 and s3 agree
    always_ff @(posedge clk) begin
        if (rst) begin
            in_s1_reg <= 4'h0;
            in_s2_reg <= 4'h0;
            in_s3_reg <= 4'h0;
        end else begin
            in_s1_reg <= in_pins;
            in_s2_reg <= in_s1_reg;
            in_s3_reg <= in_s2_reg;
        end
    end

    // Filtered input and one-cycle history for edge detection
    always_ff @(posedge clk) begin
        if (rst) begin
            in_clean_reg <= 4'h0;
            in_prev_reg  <= 4'h0;
            out_prev_reg <= `ET_RST_OUT;
        end else begin
            for (int i = 0; i < `ET_NUM_IO; i++) begin
                if (in_s2_reg[i] == in_s3_reg[i]) begin
                    in_clean_reg[i] <= in_s3_reg[i];
                end
            end
            in_prev_reg  <= in_clean_reg;
            out_prev_reg <= out_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Counter clocking and run qualification
    always_comb begin
        for (int c = 0; c < `ET_NUM_CNT; c++) begin
            // Input clock counts on its rising edge only
            tick[c]   = cfg_clk_from_pin[c]
                      ? (in_clean_reg[cfg_clk_pin[c]] & ~in_prev_reg[cfg_clk_pin[c]])
                      : 1'b1;
            // Counter 1 is unused while the pair is joined into one wide counter
            active[c] = ~halt_reg[c] & ~stop_reg[c] & tick[c]
                      & ((c == 0) | ~cfg_unify);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Match detection per match register (for converter triggers)
    always_comb begin
        for (int r = 0; r < `ET_NUM_MR; r++) begin
            mr_hit[r] = ~cfg_is_capture[r]
                      & (hit_of(cnt_reg[0], match_value[r], 1'b0, cfg_unify)
                      | (~cfg_unify & hit_of(cnt_reg[1], match_value[r], 1'b1, 1'b0)));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Event evaluation
    always_comb begin
        logic       c, io_ok, m_ok, d_ok, cond;
        logic [7:0] io_now, io_old;
        c     = 1'b0;
        io_ok = 1'b0;
        m_ok  = 1'b0;
        d_ok  = 1'b0;
        cond  = 1'b0;
        io_now = {out_reg, in_clean_reg};
        io_old = {out_prev_reg, in_prev_reg};
        for (int e = 0; e < `ET_NUM_EV; e++) begin
            c = cfg_unify ? 1'b0 : ev_counter[e];
            raw_match[e] = (ev_match_sel[e] < 3'h5)
                         & ~cfg_is_capture[ev_match_sel[e]]
                         & hit_of(cnt_reg[c], match_value[ev_match_sel[e]], c, cfg_unify);
            m_ok = raw_match[e] | pend_reg[e];
            case (io_cond_e'(ev_io_cond[e]))
                COND_LOW:  io_ok = ~io_now[ev_io_sel[e]];
                COND_RISE: io_ok = io_now[ev_io_sel[e]] & ~io_old[ev_io_sel[e]];
                COND_FALL: io_ok = ~io_now[ev_io_sel[e]] & io_old[ev_io_sel[e]];
                COND_HIGH: io_ok = io_now[ev_io_sel[e]];
                default:   io_ok = 1'b0;
            endcase
            case (comb_e'(ev_comb[e]))
                COMB_OR:    cond = m_ok | io_ok;
                COMB_MATCH: cond = m_ok;
                COMB_IO:    cond = io_ok;
                COMB_AND:   cond = m_ok & io_ok;
                default:    cond = 1'b0;
            endcase
            // Direction qualifier only has meaning for an up-down counter
            case (dir_qual_e'(ev_dir_qual[e]))
                DIRQ_ANY:  d_ok = 1'b1;
                DIRQ_UP:   d_ok = ~cfg_bidir[c] | ~dir_reg[c];
                DIRQ_DOWN: d_ok = ~cfg_bidir[c] | dir_reg[c];
                default:   d_ok = ~cfg_bidir[c];
            endcase
            fire[e] = ev_state_mask[e][state_reg] & d_ok & cond;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Gather counter actions of fired events
    always_comb begin
        logic c;
        c         = 1'b0;
        act_limit = '0;
        act_halt  = '0;
        act_stop  = '0;
        act_start = '0;
        act_rev   = '0;
        for (int e = 0; e < `ET_NUM_EV; e++) begin
            c = cfg_unify ? 1'b0 : ev_counter[e];
            act_limit[c] = act_limit[c] | (fire[e] & ev_limit[e]);
            act_halt[c]  = act_halt[c]  | (fire[e] & ev_halt[e]);
            act_stop[c]  = act_stop[c]  | (fire[e] & ev_stop[e]);
            act_start[c] = act_start[c] | (fire[e] & ev_start[e]);
            act_rev[c]   = act_rev[c]   | (fire[e] & ev_reverse[e]);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Next count and direction
    always_comb begin
        word_t lim;
        logic  at_lim;
        lim    = '0;
        at_lim = 1'b0;
        for (int c = 0; c < `ET_NUM_CNT; c++) begin
            // Auto limit from match 0 sets the shared PWM period
            lim = (cfg_auto_limit[c] & ~cfg_is_capture[0])
                ? half_of(match_value[0], c[0], cfg_unify)
                : (cfg_unify ? `ET_FULL_LIM : `ET_HALF_LIM);
            at_lim      = (cnt_reg[c] == lim) | act_limit[c];
            cnt_next[c] = cnt_reg[c];
            dir_next[c] = dir_reg[c];
            if (active[c]) begin
                if (!cfg_bidir[c]) begin
                    cnt_next[c] = at_lim ? '0 : cnt_reg[c] + 32'h1;
                    dir_next[c] = 1'b0;
                end else if (!dir_reg[c]) begin
                    if (at_lim) begin
                        dir_next[c] = 1'b1;
                        cnt_next[c] = (cnt_reg[c] == '0) ? '0 : cnt_reg[c] - 32'h1;
                    end else begin
                        cnt_next[c] = cnt_reg[c] + 32'h1;
                    end
                end else begin
                    if (cnt_reg[c] == '0) begin
                        dir_next[c] = 1'b0;
                        cnt_next[c] = 32'h1;
                    end else begin
                        cnt_next[c] = cnt_reg[c] - 32'h1;
                    end
                end
            end
            if (act_rev[c] && cfg_bidir[c]) begin
                dir_next[c] = ~dir_next[c];
            end
        end
    end

    // Counter and direction registers
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_reg[0] <= '0;
            cnt_reg[1] <= '0;
            dir_reg    <= '0;
        end else begin
            cnt_reg[0] <= cnt_next[0];
            cnt_reg[1] <= cnt_next[1];
            dir_reg    <= dir_next;
        end
    end

    // Halt needs software to release; stop can be lifted by a start event
    always_ff @(posedge clk) begin
        if (rst) begin
            halt_reg <= {`ET_NUM_CNT{1'b1}};
            stop_reg <= '0;
        end else begin
            halt_reg <= act_halt | (halt_reg & ~sw_run);
            stop_reg <= act_stop | (stop_reg & ~act_start);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State variable; lowest numbered event wins a conflict
    always_comb begin
        state_next = state_reg;
        for (int e = `ET_NUM_EV - 1; e >= 0; e--) begin
            if (fire[e] && ev_goto_en[e]) begin
                state_next = ev_goto_state[e];
            end
        end
    end

    // Untouched by counter wrap or limit so sequences span periods
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= `ET_RST_STATE;
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output toggles; two events toggling one pin cancel out
    always_comb begin
        out_next = out_reg;
        for (int e = 0; e < `ET_NUM_EV; e++) begin
            out_next = out_next ^ (ev_out_toggle[e] & {`ET_NUM_IO{fire[e]}});
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            out_reg <= `ET_RST_OUT;
        end else begin
            out_reg <= out_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Held matches: a new match sets, firing consumes
    always_ff @(posedge clk) begin
        if (rst) begin
            pend_reg <= '0;
        end else begin
            pend_reg <= ev_hold & ((pend_reg | raw_match) & ~fire);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Capture; whole count value snapshot, both halves when split
    always_comb begin
        cap_load = '0;
        for (int e = 0; e < `ET_NUM_EV; e++) begin
            cap_load = cap_load | (ev_capture[e] & {`ET_NUM_MR{fire[e]}});
        end
        cap_load = cap_load & cfg_is_capture;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            for (int r = 0; r < `ET_NUM_MR; r++) begin
                cap_reg[r] <= '0;
            end
        end else begin
            for (int r = 0; r < `ET_NUM_MR; r++) begin
                if (cap_load[r]) begin
                    cap_reg[r] <= count_value;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt, DMA and converter trigger strobes
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_reg <= '0;
            dma_reg <= 1'b0;
            adc_reg <= '0;
        end else begin
            irq_reg <= fire & ev_irq_en;
            dma_reg <= |(fire & ev_dma_en);
            adc_reg <= mr_hit[`ET_NUM_IO-1:0] | gp_match;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output assignments
    assign count_value   = cfg_unify ? cnt_reg[0] : {cnt_reg[1][15:0], cnt_reg[0][15:0]};
    assign count_down    = dir_reg;
    assign count_running = ~halt_reg & ~stop_reg;
    assign state_value   = state_reg;
    assign out_pins      = out_reg;
    assign irq_event     = irq_reg;
    assign dma_req       = dma_reg;
    assign adc_trig      = adc_reg;
    assign capture_value = {cap_reg[4], cap_reg[3], cap_reg[2], cap_reg[1], cap_reg[0]};

endmodule : state_event_timer

// ### sim/state_event_timer_properties.sv
// Port checker for the state event timer
`timescale 1ns/10ps
`include "event_timer_defines.svh"
module state_event_timer_chk
    import event_timer_pkg::*;
(
    input wire logic                                  clk,
    input wire logic                                  rst,
    input wire logic                                  cfg_unify,
    input wire logic [`ET_NUM_CNT-1:0]                cfg_clk_from_pin,
    input wire logic [`ET_NUM_CNT-1:0]                cfg_bidir,
    input wire logic [`ET_NUM_CNT-1:0]                cfg_auto_limit,
    input wire logic [`ET_NUM_MR-1:0]                 cfg_is_capture,
    input wire logic [`ET_NUM_MR-1:0][`ET_CNT_W-1:0]  match_value,
    input wire logic [`ET_NUM_EV-1:0]                 ev_limit,
    input wire logic [`ET_NUM_EV-1:0]                 ev_halt,
    input wire logic [`ET_NUM_EV-1:0]                 ev_stop,
    input wire logic [`ET_NUM_EV-1:0]                 ev_reverse,
    input wire logic [`ET_NUM_EV-1:0]                 ev_goto_en,
    input wire logic [`ET_NUM_EV-1:0][`ET_NUM_IO-1:0] ev_out_toggle,
    input wire logic [`ET_NUM_EV-1:0][`ET_NUM_MR-1:0] ev_capture,
    input wire logic [`ET_NUM_EV-1:0]                 ev_irq_en,
    input wire logic [`ET_NUM_EV-1:0]                 ev_dma_en,
    input wire logic [`ET_NUM_IO-1:0]                 gp_match,
    input wire logic [`ET_CNT_W-1:0]                  count_value,
    input wire logic [`ET_NUM_CNT-1:0]                count_down,
    input wire logic [`ET_NUM_CNT-1:0]                count_running,
    input wire logic [`ET_NUM_MR-1:0][`ET_CNT_W-1:0]  capture_value,
    input wire logic [`ET_ST_W-1:0]                   state_value,
    input wire logic [`ET_NUM_IO-1:0]                 out_pins,
    input wire logic [`ET_NUM_EV-1:0]                 irq_event,
    input wire logic                                  dma_req,
    input wire logic [`ET_NUM_IO-1:0]                 adc_trig
);
    // Plain unified counter on system clock, no counter-control events
    wire logic plain = cfg_unify && !cfg_clk_from_pin[0] && cfg_auto_limit[0] && !cfg_is_capture[0]
                       && !(|{ev_limit, ev_halt, ev_stop, ev_reverse});
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    ////////////////////
    // Counter at either end of its range
    sequence at_top;
        plain && count_running[0] && count_value == match_value[0];
    endsequence
    sequence at_bottom;
        plain && count_running[0] && count_down[0] && count_value == 32'h0;
    endsequence
    AST_UP_WRAP: assert property (!cfg_bidir[0] ##0 at_top |=> count_value == 32'h0)
        else $error("up count did not wrap at the limit");
    AST_TURN_DOWN: assert property (cfg_bidir[0] ##0 at_top |=> count_down[0]
        && count_value == match_value[0] - 32'h1) else $error("no turn down at the limit");
    AST_TURN_UP: assert property (cfg_bidir[0] ##0 at_bottom |=> !count_down[0]
        && count_value == 32'h1) else $error("no turn up at zero");
    AST_ADC_OR: assert property (1'b1 |=> (adc_trig & $past(gp_match)) == $past(gp_match))
        else $error("external match missing on converter trigger");
    AST_STATE_HOLD: assert property (ev_goto_en == '0 |=> $stable(state_value))
        else $error("state moved with no transition event");
    AST_OUT_HOLD: assert property (ev_out_toggle == '0 |=> $stable(out_pins))
        else $error("output moved with no toggle event");
    AST_CAP_HOLD: assert property (ev_capture == '0 |=> $stable(capture_value))
        else $error("capture loaded with no capture event");
    AST_NO_IRQ: assert property (1'b1 |=> (irq_event & ~$past(ev_irq_en)) == '0)
        else $error("interrupt pulse from a disabled event");
    AST_NO_DMA: assert property (ev_dma_en == '0 |=> !dma_req)
        else $error("transfer request from a disabled event");
endmodule : state_event_timer_chk
bind state_event_timer state_event_timer_chk chk_u (.*);

// ### sim/pin_partner.sv
// Far-side model: input pins, external matches, PWM watcher
`timescale 1ns/10ps
module pin_partner (
    input  wire logic            clk,
    input  wire logic [3:0]      out_pins,
    input  wire logic            measure,
    output logic      [3:0]      in_pins,
    output logic      [3:0]      gp_match,
    output logic      [3:0][7:0] hi_cnt
);
    // Pins idle low until a scenario drives them
    initial {in_pins, gp_match} = 8'h00;
    ////////////////////
    // Called at a falling edge so no race with sampling
    task automatic drive_pin(input int idx, input logic v);
        in_pins[idx] = v;
    endtask : drive_pin
    task automatic drive_match(input logic [3:0] v);
        gp_match = v;
    endtask : drive_match
    // High time per output, cleared while idle
    always_ff @(posedge clk) begin
        for (int i = 0; i < 4; i++) begin
            hi_cnt[i] <= measure ? hi_cnt[i] + 8'(out_pins[i]) : 8'h00;
        end
    end
endmodule : pin_partner

// ### sim/state_event_timer_tb.sv
// Self-checking bench for the state event timer
`timescale 1ns/10ps
`include "event_timer_defines.svh"
module state_event_timer_tb
    import event_timer_pkg::*;
;
    logic clk = 1'b0, rst = 1'b1, cfg_unify = 1'b1, dma_req, measure = 1'b0;
    logic [`ET_NUM_CNT-1:0] cfg_clk_from_pin = '0, cfg_bidir = '0, cfg_auto_limit = 2'h3, sw_run = '0;
    logic [`ET_NUM_CNT-1:0] count_down, count_running;
    logic [`ET_NUM_CNT-1:0][1:0] cfg_clk_pin = '0;
    logic [`ET_NUM_MR-1:0] cfg_is_capture = '0;
    logic [`ET_NUM_MR-1:0][`ET_CNT_W-1:0] match_value = '0, capture_value;
    logic [`ET_NUM_EV-1:0][`ET_NUM_ST-1:0] ev_state_mask = '1;
    logic [`ET_NUM_EV-1:0] ev_counter = '0, ev_hold = '0, ev_limit = '0, ev_halt = '0, ev_stop = '0,
        ev_start = '0, ev_reverse = '0, ev_goto_en = '0, ev_irq_en = '0, ev_dma_en = '0, irq_event;
    logic [`ET_NUM_EV-1:0][2:0] ev_match_sel = '1, ev_io_sel = '0, ev_goto_state = '0;
    logic [`ET_NUM_EV-1:0][1:0] ev_io_cond = '0, ev_comb = '0, ev_dir_qual = '0;
    logic [`ET_NUM_EV-1:0][`ET_NUM_IO-1:0] ev_out_toggle = '0;
    logic [`ET_NUM_EV-1:0][`ET_NUM_MR-1:0] ev_capture = '0;
    logic [`ET_NUM_IO-1:0] in_pins, gp_match, out_pins, adc_trig;
    logic [`ET_CNT_W-1:0] count_value;
    logic [`ET_ST_W-1:0] state_value;
    logic [3:0][7:0] hi_cnt;
    int errors = 0, check_count = 0;
    state_event_timer dut_u (.*);
    pin_partner partner_u (.clk(clk), .out_pins(out_pins), .measure(measure), .in_pins(in_pins),
        .gp_match(gp_match), .hi_cnt(hi_cnt));
    // 40 MHz clock
    always #12.5 clk = ~clk;
    ////////////////////
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got);
        end
    endtask : chk
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_of_test
    // Clears actions so one test cannot leak into the next
    task automatic do_reset();
        {sw_run, ev_out_toggle, ev_goto_en, ev_capture, ev_irq_en, ev_dma_en, ev_halt, cfg_bidir} = '0;
        cfg_clk_from_pin = '0;
        ev_match_sel = '1;
        ev_comb = {6{COMB_MATCH}};
        cfg_unify = 1'b1;
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
    endtask : do_reset
    // Count after k ticks: up, up-down, split halves
    function automatic logic [31:0] exp_cnt(input int m, input int k);
        if (m == 0) return 32'(k % 4);
        if (m == 1) return 32'(k % 6 > 3 ? 6 - k % 6 : k % 6);
        return {16'(k % 6), 16'(k % 3)};
    endfunction : exp_cnt
    task automatic run_seq(input int m);
        do_reset();
        cfg_unify = (m < 2);
        cfg_bidir[0] = (m == 1);
        match_value[0] = (m == 2) ? 32'h0005_0002 : 32'h0000_0003;
        sw_run = 2'h3;
        for (int i = 0; i < 9 && count_running[0] !== 1'b1; i++) @(negedge clk);
        for (int k = 0; k < 14; k++) begin
            chk("count", exp_cnt(m, k), count_value);
            if (m == 1 && k % 3 != 0) chk("down", 32'(k % 6 > 3), 32'(count_down[0]));
            @(negedge clk);
        end
        $display("count mode %0d done", m);
    endtask : run_seq
    // Two outputs, shared period of four, different duty
    task automatic pwm_test();
        do_reset();
        match_value[2:0] = {32'h2, 32'h1, 32'h3};
        ev_match_sel[2:0] = {3'h0, 3'h2, 3'h1};
        ev_out_toggle[2:0] = {4'h2, 4'h1, 4'h3};
        sw_run = 2'h1;
        repeat (12) @(negedge clk);
        measure = 1'b1;
        repeat (40) @(negedge clk);
        measure = 1'b0;
        chk("duty0", 32'd10, 32'(hi_cnt[0]));
        chk("duty1", 32'd20, 32'(hi_cnt[1]));
        ev_match_sel[3] = 3'h2;
        ev_halt[3] = 1'b1;  // Halt at match 2; sticks with run low
        sw_run = 2'h0;
        repeat (6) @(negedge clk);
        chk("halt", 32'h3, count_value);
        $display("pwm test done");
    endtask : pwm_test
    // Raise a pin and wait for the event pulse
    task automatic fire(input int ev);
        partner_u.drive_pin(0, 1'b1);
        for (int i = 0; i < 12 && irq_event[ev] !== 1'b1; i++) @(negedge clk);
    endtask : fire
    task automatic state_test();
        do_reset();
        match_value[0] = 32'h3;
        cfg_is_capture[4] = 1'b1;
        ev_comb = {6{COMB_IO}};
        ev_io_cond = {6{COND_RISE}};
        ev_state_mask = {8'h20, {4{8'hFF}}, 8'h01};
        ev_goto_en = 6'h21;
        ev_goto_state[0] = 3'h5;
        ev_capture[0] = 5'h10;
        ev_irq_en = 6'h21;
        ev_dma_en = 6'h01;
        partner_u.drive_match(4'h4);
        @(negedge clk);
        partner_u.drive_match(4'h0);
        chk("adc", 32'h1, 32'(adc_trig[2]));
        sw_run = 2'h1;
        repeat (3) @(negedge clk);
        fire(0);
        chk("irq0", 32'h1, 32'(irq_event[0]));
        chk("dma", 32'h1, 32'(dma_req));
        chk("state", 32'h5, 32'(state_value));
        chk("capture", 32'h2, capture_value[4]);
        partner_u.drive_pin(0, 1'b0);
        repeat (8) @(negedge clk);
        fire(5);
        chk("irq5", 32'h1, 32'(irq_event[5]));
        chk("masked", 32'h0, 32'(irq_event[0]));
        chk("back", 32'h0, 32'(state_value));
        $display("state test done");
    endtask : state_test
    // Counter ticks only on rising edges of input pin 2
    task automatic pin_clock_test();
        do_reset();
        match_value[0] = 32'hFF;
        cfg_clk_from_pin[0] = 1'b1;
        cfg_clk_pin[0] = 2'h2;
        sw_run = 2'h1;
        repeat (3) begin
            partner_u.drive_pin(2, 1'b1);
            repeat (6) @(negedge clk);
            partner_u.drive_pin(2, 1'b0);
            repeat (6) @(negedge clk);
        end
        chk("ticks", 32'h3, count_value);
        $display("pin clock test done");
    endtask : pin_clock_test
    ////////////////////
    // Five-cycle reset: three here, the last two inside do_reset
    initial begin
        repeat (3) @(negedge clk);
        for (int m = 0; m < 3; m++) run_seq(m);
        pwm_test();
        state_test();
        pin_clock_test();
        end_of_test();
    end
    // Tests need under 200 cycles; allow ten times that
    initial begin
        #50000;
        errors++;
        end_of_test();
    end
endmodule : state_event_timer_tb
